// ---- dpc_pkg.sv ----
package dpc_pkg;

  // Register byte offsets on the AHB-Lite port.
  localparam logic [7:0] DPC_CTRL_OFS     = 8'h00;
  localparam logic [7:0] DPC_STATUS_OFS   = 8'h04;
  localparam logic [7:0] DPC_INT_STAT_OFS = 8'h08;
  localparam logic [7:0] DPC_INT_MASK_OFS = 8'h0C;

  // Control register fields.
  localparam int DPC_CTRL_SWING_VAL  = 0;
  localparam int DPC_CTRL_SWING_OVR  = 1;
  localparam int DPC_CTRL_LF_VAL     = 2;
  localparam int DPC_CTRL_LF_OVR     = 3;
  localparam int DPC_CTRL_MAP_VAL    = 4;
  localparam int DPC_CTRL_MAP_OVR    = 5;
  localparam int DPC_CTRL_FILT_VAL   = 6;
  localparam int DPC_CTRL_FILT_OVR   = 7;
  localparam int DPC_CTRL_SSC_REQ    = 8;
  localparam int DPC_CTRL_W          = 9;

  // Status register fields.
  localparam int DPC_STAT_LOCK       = 0;
  localparam int DPC_STAT_PWR_UP     = 1;
  localparam int DPC_STAT_SWING      = 2;
  localparam int DPC_STAT_LF         = 3;
  localparam int DPC_STAT_MAP        = 4;
  localparam int DPC_STAT_MODE_LO    = 5;
  localparam int DPC_STAT_FILT       = 7;
  localparam int DPC_STAT_SSC_ON     = 8;
  localparam int DPC_STAT_OUT_LO     = 9;

  // Interrupt status and mask fields.
  localparam int DPC_INT_LOCK_GAIN   = 0;
  localparam int DPC_INT_LOCK_LOSS   = 1;
  localparam int DPC_INT_W           = 2;

  // Values after reset.
  localparam logic [DPC_CTRL_W-1:0] DPC_CTRL_RST = 9'h000;
  localparam logic [DPC_INT_W-1:0]  DPC_INT_RST  = 2'h0;

  // Operating mode field codes.
  localparam logic [1:0] DPC_MODE_CUR_NOFILT = 2'h0;
  localparam logic [1:0] DPC_MODE_CUR_FILT   = 2'h1;
  localparam logic [1:0] DPC_MODE_LEGACY     = 2'h2;

  // Highest output clock in MHz at which spread spectrum may run.
  localparam int DPC_SSC_MAX_MHZ = 65;

  // Synchroniser depth for pins.
  localparam int DPC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    DPC_OUT_HIZ,
    DPC_OUT_ACTIVE,
    DPC_OUT_SLEEP_LOW,
    DPC_OUT_HOLD_HIGH
  } dpc_out_e;

endpackage

// ---- dpc_pin_control.sv ----
// Summary of operation
// - Lock status is high once the receive PLL has locked, and then the outputs follow only the output enable.
// - Lock status is low while the PLL is unlocked, and then sleep select and output enable set the outputs.
// - With the power-down input high the device runs normally with every function enabled.
// - With the power-down input low the PLL stops, current is minimised, drivers hold high and control registers reset.
// - The swing select from pin or register picks the large swing when one and the small swing when zero.
// - The spread low-frequency select from pin or register picks low-frequency mode when one and high when zero.
// - Spread spectrum generation is never provided while the output clock is above 65 MHz.
// - The bit-map select from pin or register puts the MSBs on lane three when one and the LSBs there when zero.
// - Mode 00 expects the current serializer with the control-signal filter disabled.
// - Mode 01 expects the current serializer with the control-signal filter enabled.
// - Mode 10 adapts link decoding to the earlier serializer family.
// - The mode field comes from its two pins and registers may override it only to a limited degree.
module dpc_pin_control
  import dpc_pkg::*;
#(
  parameter int FREQ_W = 8
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              power_down_n,
  input  wire logic              pll_lock_raw,
  input  wire logic              parallel_output_enable,
  input  wire logic              sleep_state_select,
  input  wire logic              output_swing_select,
  input  wire logic              spread_low_freq_select,
  input  wire logic              bit_map_select,
  input  wire logic [1:0]        config_pins,
  input  wire logic [FREQ_W-1:0] out_clk_mhz,
  output logic                   lock,
  output logic                   pll_enable,
  output logic                   low_power,
  output logic                   driver_hold_high,
  output logic [1:0]             parallel_out_state,
  output logic                   swing_large,
  output logic                   spread_low_freq_mode,
  output logic                   spread_spectrum_enable,
  output logic                   lane_three_msb,
  output logic [1:0]             operating_mode,
  output logic                   legacy_partner,
  output logic                   ctrl_filter_enable,
  output logic                   irq
);

  // The frequency port must hold the spread spectrum limit without wrapping.
  if (FREQ_W < 7 || FREQ_W > 16)
  begin
    $error("FREQ_W must lie between 7 and 16.");
  end

  localparam int PIN_N = 9;
  localparam logic [FREQ_W-1:0] SSC_MAX = FREQ_W'(DPC_SSC_MAX_MHZ);

  logic [PIN_N-1:0]      sync1_r;
  logic [PIN_N-1:0]      sync2_r;
  logic                  pwr_up;
  logic                  lock_s;
  logic                  oen_s;
  logic                  oss_s;
  logic                  swing_s;
  logic                  lf_s;
  logic                  map_s;
  logic [1:0]            cfg_s;
  logic [DPC_CTRL_W-1:0] ctrl_r;
  logic [DPC_INT_W-1:0]  int_stat_r;
  logic [DPC_INT_W-1:0]  int_mask_r;
  logic [DPC_INT_W-1:0]  int_set;
  logic                  lock_r;
  logic                  lock_nxt;
  logic                  ap_valid;
  logic                  wr_pend_r;
  logic [7:0]            wr_addr_r;
  logic [31:0]           rd_nxt;
  logic [31:0]           status_w;
  logic [1:0]            mode_w;
  logic                  rd_int_stat;
  dpc_out_e              out_state;

  // All pins except out_clk_mhz cross into hclk through two flops before use.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {config_pins, bit_map_select, spread_low_freq_select,
                  output_swing_select, sleep_state_select,
                  parallel_output_enable, pll_lock_raw, power_down_n};
      sync2_r <= sync1_r;
    end
  end

  assign pwr_up  = sync2_r[0];
  assign lock_s  = sync2_r[1];
  assign oen_s   = sync2_r[2];
  assign oss_s   = sync2_r[3];
  assign swing_s = sync2_r[4];
  assign lf_s    = sync2_r[5];
  assign map_s   = sync2_r[6];
  assign cfg_s   = sync2_r[8:7];

  // Power control follows the synchronised power-down level.
  assign pll_enable       = pwr_up;
  assign low_power        = ~pwr_up;
  assign driver_hold_high = ~pwr_up;

  // A stopped PLL cannot report lock, whatever its raw flag shows.
  assign lock_nxt = pwr_up & lock_s;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_r <= 1'b0;
    end
    else
    begin
      lock_r <= lock_nxt;
    end
  end

  assign lock = lock_r;

  // Output state: locked follows the enable only, unlocked adds sleep select.
  always_comb
  begin
    if (!pwr_up)
    begin
      out_state = DPC_OUT_HOLD_HIGH;
    end
    else if (lock_r)
    begin
      out_state = oen_s ? DPC_OUT_ACTIVE : DPC_OUT_HIZ;
    end
    else if (oen_s && oss_s)
    begin
      out_state = DPC_OUT_SLEEP_LOW;
    end
    else
    begin
      out_state = DPC_OUT_HIZ;
    end
  end

  assign parallel_out_state = out_state;

  function automatic logic pick(input logic pin, input logic ovr, input logic val);
    pick = ovr ? val : pin;
  endfunction

  assign swing_large          = pick(swing_s, ctrl_r[DPC_CTRL_SWING_OVR],
                                     ctrl_r[DPC_CTRL_SWING_VAL]);
  assign spread_low_freq_mode = pick(lf_s, ctrl_r[DPC_CTRL_LF_OVR],
                                     ctrl_r[DPC_CTRL_LF_VAL]);
  assign lane_three_msb       = pick(map_s, ctrl_r[DPC_CTRL_MAP_OVR],
                                     ctrl_r[DPC_CTRL_MAP_VAL]);

  // Above the limit the generator is forced off even if software asks for it.
  assign spread_spectrum_enable = pwr_up & ctrl_r[DPC_CTRL_SSC_REQ]
                                  & (out_clk_mhz <= SSC_MAX);

  // Software may only flip the filter bit, and only for a current-family
  // partner; the partner family itself always comes from the pins.
  always_comb
  begin
    mode_w = cfg_s;
    if (ctrl_r[DPC_CTRL_FILT_OVR] && !cfg_s[1])
    begin
      mode_w = ctrl_r[DPC_CTRL_FILT_VAL] ? DPC_MODE_CUR_FILT
                                         : DPC_MODE_CUR_NOFILT;
    end
  end

  assign operating_mode     = mode_w;
  assign ctrl_filter_enable = (mode_w == DPC_MODE_CUR_FILT);
  assign legacy_partner     = mode_w[1];

  // AHB-Lite slave, zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_valid  = hsel & htrans[1] & hready;
  assign rd_int_stat = ap_valid & ~hwrite & (haddr[7:0] == DPC_INT_STAT_OFS)
                       & (haddr[31:8] == 24'h000000);

  always_comb
  begin
    status_w = 32'h00000000;
    status_w[DPC_STAT_LOCK]   = lock_r;
    status_w[DPC_STAT_PWR_UP] = pwr_up;
    status_w[DPC_STAT_SWING]  = swing_large;
    status_w[DPC_STAT_LF]     = spread_low_freq_mode;
    status_w[DPC_STAT_MAP]    = lane_three_msb;
    status_w[DPC_STAT_MODE_LO +: 2] = mode_w;
    status_w[DPC_STAT_FILT]   = ctrl_filter_enable;
    status_w[DPC_STAT_SSC_ON] = spread_spectrum_enable;
    status_w[DPC_STAT_OUT_LO +: 2]  = out_state;
  end

  always_comb
  begin
    rd_nxt = 32'h00000000;
    if (haddr[31:8] != 24'h000000)
    begin
      rd_nxt = 32'h00000000;
    end
    else if (haddr[7:0] == DPC_CTRL_OFS)
    begin
      rd_nxt = {{(32-DPC_CTRL_W){1'b0}}, ctrl_r};
    end
    else if (haddr[7:0] == DPC_STATUS_OFS)
    begin
      rd_nxt = status_w;
    end
    else if (haddr[7:0] == DPC_INT_STAT_OFS)
    begin
      rd_nxt = {{(32-DPC_INT_W){1'b0}}, int_stat_r};
    end
    else if (haddr[7:0] == DPC_INT_MASK_OFS)
    begin
      rd_nxt = {{(32-DPC_INT_W){1'b0}}, int_mask_r};
    end
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (ap_valid && !hwrite)
    begin
      hrdata <= rd_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= ap_valid & hwrite & (haddr[31:8] == 24'h000000);
      if (ap_valid)
      begin
        wr_addr_r <= haddr[7:0];
      end
    end
  end

  // Power-down clears every control register, not only hresetn.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r     <= DPC_CTRL_RST;
      int_mask_r <= DPC_INT_RST;
    end
    else if (!pwr_up)
    begin
      ctrl_r     <= DPC_CTRL_RST;
      int_mask_r <= DPC_INT_RST;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == DPC_CTRL_OFS)
      begin
        ctrl_r <= hwdata[DPC_CTRL_W-1:0];
      end
      else if (wr_addr_r == DPC_INT_MASK_OFS)
      begin
        int_mask_r <= hwdata[DPC_INT_W-1:0];
      end
    end
  end

  assign int_set[DPC_INT_LOCK_GAIN] = lock_nxt & ~lock_r;
  assign int_set[DPC_INT_LOCK_LOSS] = ~lock_nxt & lock_r;

  // A lock edge in the same cycle as the clearing read is kept.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_stat_r <= DPC_INT_RST;
    end
    else if (!pwr_up)
    begin
      int_stat_r <= int_set;
    end
    else if (rd_int_stat)
    begin
      int_stat_r <= int_set;
    end
    else
    begin
      int_stat_r <= int_stat_r | int_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |((int_stat_r | int_set) & int_mask_r);
    end
  end

endmodule

// ---- dpc_pin_control_chk.sv ----
module dpc_chk
  import dpc_pkg::*;
#(
  parameter int FREQ_W = 8
)
(
  input logic              hclk,
  input logic              hresetn,
  input logic              power_down_n,
  input logic              pll_lock_raw,
  input logic              parallel_output_enable,
  input logic [1:0]        config_pins,
  input logic [FREQ_W-1:0] out_clk_mhz,
  input logic              lock,
  input logic              pll_enable,
  input logic              low_power,
  input logic              driver_hold_high,
  input logic [1:0]        parallel_out_state,
  input logic              spread_spectrum_enable,
  input logic [1:0]        operating_mode,
  input logic              legacy_partner,
  input logic              ctrl_filter_enable,
  input logic              irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] settle_r;
  // The sync flops refill for a few edges after reset, so checks wait for them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_r <= 2'h0;
    end
    else if (settle_r != 2'h3)
    begin
      settle_r <= settle_r + 2'h1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || settle_r != 2'h3);
  // Pins cross two sync flops and lock one more register, which sets the run lengths.
  a_lock_gain: assert property ((pll_lock_raw && power_down_n)[*4] |-> lock)
    else $error("lock missing");
  a_lock_drop: assert property (!power_down_n[*3] |=> !lock)
    else $error("lock while down");
  a_out_locked: assert property ((power_down_n && $stable(parallel_output_enable))[*3]
    ##0 lock |-> parallel_out_state == (parallel_output_enable ? DPC_OUT_ACTIVE : DPC_OUT_HIZ))
    else $error("locked output state");
  a_pd_hold: assert property (!power_down_n[*3] |-> driver_hold_high && low_power
    && !pll_enable && parallel_out_state == DPC_OUT_HOLD_HIGH)
    else $error("power down state");
  a_pu_run: assert property (power_down_n[*3] |-> pll_enable && !low_power)
    else $error("not running");
  a_ssc_limit: assert property (spread_spectrum_enable |-> pll_enable
    && out_clk_mhz <= DPC_SSC_MAX_MHZ)
    else $error("spread spectrum limit");
  a_mode_family: assert property ($stable(config_pins)[*3]
    |-> legacy_partner == config_pins[1])
    else $error("partner family");
  a_filt_mode: assert property (ctrl_filter_enable
    |-> operating_mode == DPC_MODE_CUR_FILT && !legacy_partner)
    else $error("filter mode");
  c_active: cover property (lock && parallel_out_state == DPC_OUT_ACTIVE);
  c_ssc: cover property (spread_spectrum_enable);
  c_irq: cover property ($rose(irq));
endmodule

// ---- dpc_link_model.sv ----
module dpc_link_model
#(
  parameter int LOCK_DLY = 5
)
(
  input  wire logic hclk,
  input  wire logic power_down_n,
  input  wire logic link_up,
  output logic      pll_lock_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  // The PLL needs a stretch of live stream to settle; a dead link drops it at once.
  always_ff @(posedge hclk)
  begin
    if (!(power_down_n && link_up))
      cnt <= 0;
    else if (cnt < LOCK_DLY)
      cnt <= cnt + 1;
    pll_lock_raw <= power_down_n && link_up && cnt == LOCK_DLY;
  end
endmodule

// ---- tb_dpc_pin_control.sv ----
module tb_dpc_pin_control
  import dpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        power_down_n = 1'b1;
  logic        link_up = 1'b0;
  logic        parallel_output_enable = 1'b1;
  logic        sleep_state_select = 1'b1;
  logic        output_swing_select = 1'b0;
  logic        spread_low_freq_select = 1'b0;
  logic        bit_map_select = 1'b0;
  logic [1:0]  config_pins = 2'h0;
  logic [7:0]  out_clk_mhz = 8'h14;
  logic        pll_lock_raw, hreadyout, hresp, lock, pll_enable, low_power, driver_hold_high;
  logic        swing_large, spread_low_freq_mode, spread_spectrum_enable, lane_three_msb;
  logic        legacy_partner, ctrl_filter_enable, irq;
  logic [1:0]  parallel_out_state, operating_mode;
  logic [31:0] hrdata, q;
  logic [9:0]  rows [4] = '{10'h021, 10'h14A, 10'h294, 10'h3F7};
  logic [7:0]  freqs [3] = '{8'h41, 8'h42, 8'h0A};
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire [4:0]   mode_out = {legacy_partner, ctrl_filter_enable, lane_three_msb,
                           spread_low_freq_mode, swing_large};

  dpc_pin_control dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .power_down_n, .pll_lock_raw, .parallel_output_enable,
    .sleep_state_select, .output_swing_select, .spread_low_freq_select, .bit_map_select,
    .config_pins, .out_clk_mhz, .lock, .pll_enable, .low_power, .driver_hold_high,
    .parallel_out_state, .swing_large, .spread_low_freq_mode, .spread_spectrum_enable,
    .lane_three_msb, .operating_mode, .legacy_partner, .ctrl_filter_enable, .irq);
  dpc_link_model lm (.hclk, .power_down_n, .link_up, .pll_lock_raw);

  always #12.5 hclk = ~hclk;

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(32'(hresp), 32'h0);
    chk(q, e);
  endtask

  task automatic pins(input logic [4:0] v);
    @(posedge hclk);
    {config_pins, bit_map_select, spread_low_freq_select, output_swing_select} <= v;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic wait_lock(input logic v);
    for (int i = 0; i < 20 && lock !== v; i++)
      @(negedge hclk);
    chk(32'(lock), 32'(v));
  endtask

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      pins(rows[i][9:5]);
      chk(32'(mode_out), 32'(rows[i][4:0]));
    end
    rd(32'h0, 32'h0);
    rd(32'hC, 32'h0);
    ahb(1'b1, 32'h100, 32'h1FF);
    rd(32'h100, 32'h0);
    rd(32'h0, 32'h0);
    pins(5'h00);
    ahb(1'b1, 32'h0, 32'hFF);
    @(negedge hclk);
    chk(32'(mode_out), 32'h0F);
    pins(5'h10);
    chk(32'(mode_out), 32'h17);
    ahb(1'b1, 32'h0, 32'h100);
    foreach (freqs[i])
    begin
      @(posedge hclk);
      out_clk_mhz <= freqs[i];
      @(negedge hclk);
      chk(32'(spread_spectrum_enable), 32'(freqs[i] <= 8'h41));
    end
    ahb(1'b1, 32'hC, 32'h1);
    link_up <= 1'b1;
    wait_lock(1'b1);
    chk(32'(parallel_out_state), 32'(DPC_OUT_ACTIVE));
    rd(32'h4, 32'h343);
    repeat (3) @(negedge hclk);
    chk(32'(irq), 32'h1);
    rd(32'h8, 32'h1);
    repeat (2) @(negedge hclk);
    chk(32'(irq), 32'h0);
    @(posedge hclk);
    parallel_output_enable <= 1'b0;
    repeat (3) @(negedge hclk);
    chk(32'(parallel_out_state), 32'(DPC_OUT_HIZ));
    @(posedge hclk);
    parallel_output_enable <= 1'b1;
    link_up <= 1'b0;
    wait_lock(1'b0);
    chk(32'(parallel_out_state), 32'(DPC_OUT_SLEEP_LOW));
    rd(32'h8, 32'h2);
    @(negedge hclk);
    chk(32'(irq), 32'h0);
    @(posedge hclk);
    link_up <= 1'b1;
    wait_lock(1'b1);
    ahb(1'b1, 32'h0, 32'h3F);
    power_down_n <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(32'({driver_hold_high, low_power, pll_enable, lock, parallel_out_state}), 32'h33);
    rd(32'h0, 32'h0);
    ahb(1'b1, 32'h0, 32'h3F);
    rd(32'h0, 32'h0);
    rd(32'hC, 32'h0);
    power_down_n <= 1'b1;
    wait_lock(1'b1);
    ahb(1'b1, 32'h0, 32'h3F);
    hresetn <= 1'b0;
    repeat (2) @(negedge hclk);
    chk(32'({lock, irq, pll_enable, driver_hold_high}), 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h0, 32'h0);
    wait_lock(1'b1);
    end_sim();
  end
endmodule

bind dpc_pin_control dpc_chk #(.FREQ_W(FREQ_W)) u_chk (
  .hclk, .hresetn, .power_down_n, .pll_lock_raw, .parallel_output_enable, .config_pins,
  .out_clk_mhz, .lock, .pll_enable, .low_power, .driver_hold_high, .parallel_out_state,
  .spread_spectrum_enable, .operating_mode, .legacy_partner, .ctrl_filter_enable, .irq);
